// *** common/lps_pkg.sv ***
// Shared states and timing constants for the low-power state controller
package lps_pkg;

  // ----------------------------------------------------------------
  // Device power states
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    LPS_NORMAL  = 7'h01,
    LPS_HALTED  = 7'h02,
    LPS_STOPACK = 7'h04,
    LPS_SNOOP   = 7'h08,
    LPS_SLEEP   = 7'h10,
    LPS_DEEP    = 7'h20,
    LPS_WAKE    = 7'h40
  } lps_state_e;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 125;
  localparam int PLL_STAB_TIME_US = 1000;
  localparam int PLL_STAB_CYC     = PLL_STAB_TIME_US * CLK_MHZ;
  localparam int SLEEP_MIN_CYC    = 1;
  localparam int RESET_HOLD_CYC   = 16;
  localparam int SNOOP_LEN_CYC    = 4;
  localparam int CNT_W            = 17;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic lps_is_asleep(input lps_state_e s);
    lps_is_asleep = (s == LPS_SLEEP) || (s == LPS_DEEP) || (s == LPS_WAKE);
  endfunction

endpackage

// *** common/lps_if.sv ***
// Link between the low-power device and the platform logic
`timescale 1ns/1ns
interface lps_if;
  import lps_pkg::*;

  // Platform to device
  logic       clock_stop_request_n;
  logic       sleep_request_n;
  logic       bus_clock_run;
  logic       interrupt_ctrl_clock;
  logic       bus_reset;
  logic       snoop_valid;
  logic       snoop_done;
  // Device to platform
  lps_state_e state_code;
  logic       snoop_ack;

  modport dev (
    input  clock_stop_request_n,
    input  sleep_request_n,
    input  bus_clock_run,
    input  interrupt_ctrl_clock,
    input  bus_reset,
    input  snoop_valid,
    input  snoop_done,
    output state_code,
    output snoop_ack
  );

  modport host (
    output clock_stop_request_n,
    output sleep_request_n,
    output bus_clock_run,
    output interrupt_ctrl_clock,
    output bus_reset,
    output snoop_valid,
    output snoop_done,
    input  state_code,
    input  snoop_ack
  );
endinterface

// *** verilog/lps_dev.sv ***
// Device end: low-power state sequencer
// Function
// - Snoop in halted or stop-ack enters snoop
// - Stay in snoop until snoop serviced
// - After snoop return to prior low-power state
// - Sleep entered from stop-ack on request, or from wake
// - Sleep request ignored in normal or halted
// - Sleep stops core clocks, keeps PLL, context
// - Platform issues no snoop around sleep
// - Platform holds bus inputs steady in sleep
// - Sleep: no snoop response, no interrupt latching
// - Reset during sleep resets directly
// - Platform drops sleep, stop requests after reset
// - Sleep request held at least one period
// - Bus clock stopped in sleep gives deep sleep
// - Bus clock held low in deep sleep
// - Clock restart plus 1 ms returns sleep
// - Sleep request released returns to stop-ack
// - Deep sleep: no snoop, no interrupt latching
// - Platform changes no bus signal in deep
// - Interrupt clock runs unless sleep or deep
// - Interrupt clock restarts with bus clock
// - Stop-clock request enters stop-ack
// - Stop-clock release returns to normal
`timescale 1ns/1ns
module lps_dev #(
  parameter int PLL_CYC = lps_pkg::PLL_STAB_CYC
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // Link to platform
  lps_if.dev                      bus,
  // Core side
  input  wire logic               halt_exec,
  input  wire logic               wake_event,
  input  wire logic               intr_in,
  input  wire logic               intr_ack,
  output      lps_pkg::lps_state_e state_o,
  output      logic               core_clk_en,
  output      logic               pll_en,
  output      logic               intr_pending,
  output      logic               violation
);
  import lps_pkg::*;

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  lps_state_e             state_ff;
  lps_state_e             nxt_state;
  logic                   ret_halt_ff;
  logic                   nxt_ret_halt;
  logic [CNT_W-1:0]       cnt_ff;
  logic [CNT_W-1:0]       nxt_cnt;
  logic                   core_clk_en_ff;
  logic                   nxt_core_clk_en;
  logic                   pll_en_ff;
  logic                   nxt_pll_en;
  logic                   snoop_ack_ff;
  logic                   nxt_snoop_ack;
  logic                   intr_pending_ff;
  logic                   nxt_intr_pending;
  logic                   violation_ff;
  logic                   nxt_violation;
  logic                   stop_n_q_ff;
  logic                   nxt_stop_n_q;

  logic                   stop_req;
  logic                   sleep_req;
  logic                   asleep;

  assign stop_req  = ~bus.clock_stop_request_n;
  assign sleep_req = ~bus.sleep_request_n;
  assign asleep    = lps_is_asleep(state_ff);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state    = state_ff;
    nxt_ret_halt = ret_halt_ff;
    nxt_cnt      = cnt_ff;
    if (bus.bus_reset) begin
      // Reset goes straight to normal, even from sleep
      nxt_state = LPS_NORMAL;
    end else begin
      unique case (state_ff)
        LPS_NORMAL: begin
          if (stop_req) begin
            nxt_state = LPS_STOPACK;
          end else if (halt_exec) begin
            nxt_state = LPS_HALTED;
          end
        end
        LPS_HALTED: begin
          // Sleep request has no effect here
          if (bus.snoop_valid) begin
            nxt_state    = LPS_SNOOP;
            nxt_ret_halt = 1'b1;
          end else if (stop_req) begin
            nxt_state = LPS_STOPACK;
          end else if (wake_event) begin
            nxt_state = LPS_NORMAL;
          end
        end
        LPS_STOPACK: begin
          if (bus.snoop_valid) begin
            nxt_state    = LPS_SNOOP;
            nxt_ret_halt = 1'b0;
          end else if (sleep_req) begin
            nxt_state = LPS_SLEEP;
          end else if (!stop_req) begin
            nxt_state = LPS_NORMAL;
          end
        end
        LPS_SNOOP: begin
          // Serviced by this device or another agent alike
          if (bus.snoop_done) begin
            nxt_state = ret_halt_ff ? LPS_HALTED : LPS_STOPACK;
          end
        end
        LPS_SLEEP: begin
          if (!bus.bus_clock_run) begin
            nxt_state = LPS_DEEP;
          end else if (!sleep_req) begin
            nxt_state = LPS_STOPACK;
          end
        end
        LPS_DEEP: begin
          if (bus.bus_clock_run) begin
            nxt_state = LPS_WAKE;
            nxt_cnt   = '0;
          end
        end
        LPS_WAKE: begin
          // PLL must settle before the device returns to the sleep state
          if (!bus.bus_clock_run) begin
            nxt_state = LPS_DEEP;
          end else if (cnt_ff == CNT_W'(PLL_CYC - 1)) begin
            nxt_state = LPS_SLEEP;
          end else begin
            nxt_cnt = cnt_ff + CNT_W'(1);
          end
        end
        default: begin
          nxt_state = LPS_NORMAL;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff    <= LPS_NORMAL;
      ret_halt_ff <= 1'b0;
      cnt_ff      <= '0;
    end else begin
      state_ff    <= nxt_state;
      ret_halt_ff <= nxt_ret_halt;
      cnt_ff      <= nxt_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Clock gating, snoop response and interrupt capture
  // ----------------------------------------------------------------
  always_comb begin
    // Context is held by keeping flops unclocked, not reset
    nxt_core_clk_en = !lps_is_asleep(nxt_state);
    // PLL keeps running in sleep; only a stopped bus clock drops it
    nxt_pll_en      = (nxt_state != LPS_DEEP);
    nxt_snoop_ack   = (nxt_state == LPS_SNOOP);
    nxt_intr_pending = intr_pending_ff;
    if (intr_ack && state_ff == LPS_NORMAL) begin
      nxt_intr_pending = 1'b0;
    end
    // Set wins over a same-cycle acknowledge
    if (intr_in && !asleep) begin
      nxt_intr_pending = 1'b1;
    end
    nxt_stop_n_q  = bus.clock_stop_request_n;
    nxt_violation = violation_ff;
    // Flag platform misbehaviour the device cannot survive cleanly
    if (asleep && bus.snoop_valid) begin
      nxt_violation = 1'b1;
    end
    if (asleep && !bus.bus_reset && (bus.clock_stop_request_n != stop_n_q_ff)) begin
      nxt_violation = 1'b1;
    end
    if (state_ff == LPS_DEEP && bus.sleep_request_n) begin
      nxt_violation = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      core_clk_en_ff  <= 1'b1;
      pll_en_ff       <= 1'b1;
      snoop_ack_ff    <= 1'b0;
      intr_pending_ff <= 1'b0;
      violation_ff    <= 1'b0;
      stop_n_q_ff     <= 1'b1;
    end else begin
      core_clk_en_ff  <= nxt_core_clk_en;
      pll_en_ff       <= nxt_pll_en;
      snoop_ack_ff    <= nxt_snoop_ack;
      intr_pending_ff <= nxt_intr_pending;
      violation_ff    <= nxt_violation;
      stop_n_q_ff     <= nxt_stop_n_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign state_o        = state_ff;
  assign bus.state_code = state_ff;
  // No answer to snoops in sleep or deep sleep
  assign bus.snoop_ack  = snoop_ack_ff;
  assign core_clk_en    = core_clk_en_ff;
  assign pll_en         = pll_en_ff;
  assign intr_pending   = intr_pending_ff;
  assign violation      = violation_ff;

endmodule

// *** verilog/lps_host.sv ***
// Platform end: drives stop, sleep, clocks, reset and snoops
`timescale 1ns/1ns
module lps_host #(
  parameter int RESET_HOLD = lps_pkg::RESET_HOLD_CYC,
  parameter int SNOOP_LEN  = lps_pkg::SNOOP_LEN_CYC,
  parameter int SLEEP_MIN  = lps_pkg::SLEEP_MIN_CYC
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Link to device
  lps_if.host       bus,
  // Platform requests
  input  wire logic stop_req,
  input  wire logic sleep_req,
  input  wire logic deep_req,
  input  wire logic snoop_req,
  input  wire logic reset_req,
  output      logic reset_active,
  output      logic snoop_busy
);
  import lps_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LPS_H_IDLE  = 2'h1,
    LPS_H_SNOOP = 2'h2
  } lps_hstate_e;

  lps_hstate_e      hst_ff;
  lps_hstate_e      nxt_hst;
  logic [7:0]       snp_cnt_ff;
  logic [7:0]       nxt_snp_cnt;
  logic [7:0]       rst_cnt_ff;
  logic [7:0]       nxt_rst_cnt;
  logic [7:0]       slp_cnt_ff;
  logic [7:0]       nxt_slp_cnt;
  logic             stop_n_ff;
  logic             nxt_stop_n;
  logic             sleep_n_ff;
  logic             nxt_sleep_n;
  logic             run_ff;
  logic             nxt_run;
  logic             done_ff;
  logic             nxt_done;
  logic             rst_on_ff;
  logic             nxt_rst_on;
  logic             snp_on_ff;
  logic             nxt_snp_on;
  logic             asleep;

  assign asleep = lps_is_asleep(bus.state_code);

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  always_comb begin
    nxt_hst     = hst_ff;
    nxt_snp_cnt = snp_cnt_ff;
    nxt_rst_cnt = rst_cnt_ff;
    nxt_slp_cnt = slp_cnt_ff;
    nxt_stop_n  = stop_n_ff;
    nxt_sleep_n = sleep_n_ff;
    nxt_run     = run_ff;
    nxt_done    = 1'b0;
    if (rst_cnt_ff != 8'h00) begin
      nxt_rst_cnt = rst_cnt_ff - 8'h01;
    end else if (reset_req) begin
      nxt_rst_cnt = 8'(RESET_HOLD);
    end
    if (slp_cnt_ff != 8'h00) begin
      nxt_slp_cnt = slp_cnt_ff - 8'h01;
    end
    if (reset_req || rst_cnt_ff != 8'h00) begin
      // Release both requests so the reset sequence runs cleanly
      nxt_stop_n  = 1'b1;
      nxt_sleep_n = 1'b1;
      nxt_run     = 1'b1;
    end else begin
      // Stop request frozen while the device sleeps
      if (!asleep) begin
        nxt_stop_n = ~stop_req;
      end
      if (sleep_n_ff && sleep_req && stop_req && hst_ff == LPS_H_IDLE
          && bus.state_code == LPS_STOPACK) begin
        nxt_sleep_n = 1'b0;
        nxt_slp_cnt = 8'(SLEEP_MIN);
      end else if (!sleep_n_ff && !sleep_req && slp_cnt_ff == 8'h00
                   && bus.state_code == LPS_SLEEP && run_ff) begin
        nxt_sleep_n = 1'b1;
      end
      // Bus and interrupt clocks stop together, only from sleep
      if (deep_req && bus.state_code == LPS_SLEEP && !sleep_n_ff) begin
        nxt_run = 1'b0;
      end else if (!deep_req) begin
        nxt_run = 1'b1;
      end
    end
    unique case (hst_ff)
      LPS_H_IDLE: begin
        // No snoop once sleep is requested or reached
        // A sleep request raised this cycle wins over a new snoop
        if (snoop_req && !asleep && sleep_n_ff && nxt_sleep_n && rst_cnt_ff == 8'h00) begin
          nxt_hst     = LPS_H_SNOOP;
          nxt_snp_cnt = 8'(SNOOP_LEN);
        end
      end
      LPS_H_SNOOP: begin
        if (snp_cnt_ff <= 8'h01) begin
          nxt_hst  = LPS_H_IDLE;
          nxt_done = 1'b1;
        end else begin
          nxt_snp_cnt = snp_cnt_ff - 8'h01;
        end
      end
      default: begin
        nxt_hst = LPS_H_IDLE;
      end
    endcase
    nxt_rst_on = (nxt_rst_cnt != 8'h00);
    nxt_snp_on = (nxt_hst == LPS_H_SNOOP);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hst_ff     <= LPS_H_IDLE;
      snp_cnt_ff <= 8'h00;
      rst_cnt_ff <= 8'h00;
      slp_cnt_ff <= 8'h00;
      stop_n_ff  <= 1'b1;
      sleep_n_ff <= 1'b1;
      run_ff     <= 1'b1;
      done_ff    <= 1'b0;
      rst_on_ff  <= 1'b0;
      snp_on_ff  <= 1'b0;
    end else begin
      hst_ff     <= nxt_hst;
      snp_cnt_ff <= nxt_snp_cnt;
      rst_cnt_ff <= nxt_rst_cnt;
      slp_cnt_ff <= nxt_slp_cnt;
      stop_n_ff  <= nxt_stop_n;
      sleep_n_ff <= nxt_sleep_n;
      run_ff     <= nxt_run;
      done_ff    <= nxt_done;
      rst_on_ff  <= nxt_rst_on;
      snp_on_ff  <= nxt_snp_on;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus.clock_stop_request_n = stop_n_ff;
  assign bus.sleep_request_n      = sleep_n_ff;
  assign bus.bus_clock_run        = run_ff;
  assign bus.interrupt_ctrl_clock = run_ff;
  assign bus.bus_reset            = rst_on_ff;
  assign bus.snoop_valid          = snp_on_ff;
  assign bus.snoop_done           = done_ff;
  assign reset_active             = rst_on_ff;
  assign snoop_busy               = snp_on_ff;

endmodule

// *** sim/lps_assertions.sv ***
// Checker on the link between the platform end and the device end
`timescale 1ns/1ns
module lps_assertions #(
  parameter int PLL_CYC = 20
) (
  // Clock and reset
  input wire logic                clock,
  input wire logic                rst,
  // Platform to device
  input wire logic                clock_stop_request_n,
  input wire logic                sleep_request_n,
  input wire logic                bus_clock_run,
  input wire logic                interrupt_ctrl_clock,
  input wire logic                bus_reset,
  input wire logic                snoop_valid,
  input wire logic                snoop_done,
  // Device to platform
  input wire lps_pkg::lps_state_e state_code,
  input wire logic                snoop_ack
);
  import lps_pkg::*;

  // ----------------------------------------------------------------
  // Helpers: state left for a snoop, cycles spent waiting on the PLL
  // ----------------------------------------------------------------
  lps_state_e  org_ff, nxt_org;
  logic [16:0] wk_ff, nxt_wk;

  always_comb begin
    nxt_org = (state_code == LPS_SNOOP) ? org_ff : state_code;
    nxt_wk  = (state_code == LPS_WAKE) ? wk_ff + 17'h00001 : 17'h00000;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      org_ff <= LPS_NORMAL;
      wk_ff  <= 17'h00000;
    end else begin
      org_ff <= nxt_org;
      wk_ff  <= nxt_wk;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_snoop_entry: assert property (
    state_code inside {LPS_HALTED, LPS_STOPACK} && snoop_valid && !bus_reset |=> state_code == LPS_SNOOP)
    else $error("snoop state not entered");
  a_snoop_hold: assert property (
    state_code == LPS_SNOOP && !snoop_done && !bus_reset |=> state_code == LPS_SNOOP)
    else $error("snoop state left early");
  a_snoop_back: assert property (
    state_code == LPS_SNOOP && snoop_done && !bus_reset |=> state_code == org_ff)
    else $error("snoop did not return to origin");
  a_sleep_from: assert property (
    state_code == LPS_SLEEP && $past(state_code) != LPS_SLEEP |-> $past(state_code) inside {LPS_STOPACK, LPS_WAKE})
    else $error("sleep entered from wrong state");
  a_sleep_entry: assert property (
    state_code == LPS_STOPACK && !sleep_request_n && !snoop_valid && !bus_reset |=> state_code == LPS_SLEEP)
    else $error("sleep not entered");
  a_deep_entry: assert property (
    state_code == LPS_SLEEP && !bus_clock_run && !bus_reset |=> state_code == LPS_DEEP)
    else $error("deep sleep not entered");
  a_pll_wait: assert property (
    state_code == LPS_SLEEP && $past(state_code) == LPS_WAKE |-> wk_ff == 17'(PLL_CYC))
    else $error("wrong PLL settle time");
  a_sleep_exit: assert property (
    state_code == LPS_SLEEP && bus_clock_run && sleep_request_n && !bus_reset |=> state_code == LPS_STOPACK)
    else $error("sleep release not taken");
  a_reset_direct: assert property (
    bus_reset |=> state_code == LPS_NORMAL)
    else $error("bus reset not taken");
  a_stop_entry: assert property (
    state_code == LPS_NORMAL && !clock_stop_request_n && !bus_reset |=> state_code == LPS_STOPACK)
    else $error("stop request not taken");
  a_stop_release: assert property (
    state_code == LPS_STOPACK && clock_stop_request_n && sleep_request_n && !snoop_valid && !bus_reset
    |=> state_code == LPS_NORMAL)
    else $error("stop release not taken");
  a_ack_state: assert property (
    snoop_ack == (state_code == LPS_SNOOP))
    else $error("snoop answer outside snoop state");
  a_pic_awake: assert property (
    state_code inside {LPS_HALTED, LPS_STOPACK} |-> interrupt_ctrl_clock)
    else $error("interrupt clock stopped while awake");
  a_pic_with_bus: assert property (
    interrupt_ctrl_clock == bus_clock_run)
    else $error("interrupt clock apart from bus clock");
endmodule

// *** sim/low_power_state_ctrl_tb_top.sv ***
// Bench joining platform and device ends over the link
`timescale 1ns/1ns
module low_power_state_ctrl_tb_top;
  import lps_pkg::*;

  // ----------------------------------------------------------------
  // Signals; drv = stop, sleep, deep, snoop, reset, halt, wake, intr, ack
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [8:0] drv;
    lps_state_e st;
    logic [2:0] en;
  } lps_row_s;

  localparam int PLL = 20;
  logic       clock;
  logic       rst;
  logic [8:0] drv;
  lps_state_e state_o;
  logic       core_clk_en, pll_en, intr_pending, violation, reset_active, snoop_busy;
  int         n_mismatch = 0;
  int         checked = 0;

  // Enables: care bit, then core clock, then PLL
  lps_row_s rows [15] = '{
    '{9'h100, LPS_STOPACK, 3'h7},
    '{9'h180, LPS_SLEEP, 3'h5},
    '{9'h1C0, LPS_DEEP, 3'h4},
    '{9'h180, LPS_SLEEP, 3'h5},
    '{9'h100, LPS_STOPACK, 3'h7},
    '{9'h120, LPS_SNOOP, 3'h0},
    '{9'h100, LPS_STOPACK, 3'h7},
    '{9'h000, LPS_NORMAL, 3'h7},
    '{9'h008, LPS_HALTED, 3'h0},
    '{9'h020, LPS_SNOOP, 3'h0},
    '{9'h000, LPS_HALTED, 3'h0},
    '{9'h004, LPS_NORMAL, 3'h7},
    '{9'h008, LPS_HALTED, 3'h0},
    '{9'h100, LPS_STOPACK, 3'h7},
    '{9'h000, LPS_NORMAL, 3'h7}
  };

  lps_if lps_if_inst ();

  lps_host lps_host_inst (
    .clock(clock), .rst(rst), .bus(lps_if_inst), .stop_req(drv[8]), .sleep_req(drv[7]), .deep_req(drv[6]),
    .snoop_req(drv[5]), .reset_req(drv[4]), .reset_active(reset_active), .snoop_busy(snoop_busy));

  lps_dev #(.PLL_CYC(PLL)) lps_dev_inst (
    .clock(clock), .rst(rst), .bus(lps_if_inst), .halt_exec(drv[3]), .wake_event(drv[2]), .intr_in(drv[1]),
    .intr_ack(drv[0]), .state_o(state_o), .core_clk_en(core_clk_en), .pll_en(pll_en),
    .intr_pending(intr_pending), .violation(violation));

  lps_assertions #(.PLL_CYC(PLL)) lps_assertions_inst (
    .clock(clock), .rst(rst), .clock_stop_request_n(lps_if_inst.clock_stop_request_n),
    .sleep_request_n(lps_if_inst.sleep_request_n), .bus_clock_run(lps_if_inst.bus_clock_run),
    .interrupt_ctrl_clock(lps_if_inst.interrupt_ctrl_clock), .bus_reset(lps_if_inst.bus_reset),
    .snoop_valid(lps_if_inst.snoop_valid), .snoop_done(lps_if_inst.snoop_done),
    .state_code(lps_if_inst.state_code), .snoop_ack(lps_if_inst.snoop_ack));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_st(input string nm, input lps_state_e e, input lps_state_e g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_f(input string nm, input logic [1:0] e, input logic [1:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic step(input logic [8:0] v);
    @(posedge clock);
    #1 drv = v;
  endtask

  // Bounded so a stuck state machine ends the run instead of hanging it
  task automatic wait_st(input lps_state_e s);
    int i;
    i = 0;
    while (state_o !== s && i < 200) begin
      @(posedge clock);
      #1 i++;
    end
    chk_st("state", s, state_o);
    if (state_o !== s) end_of_test();
  endtask

  task automatic chk_rst();
    chk_st("reset state", LPS_NORMAL, state_o);
    chk_f("reset flags", 2'h3, {core_clk_en, pll_en});
    chk_f("reset sticky", 2'h0, {intr_pending, violation});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    drv = 9'h000;
    repeat (6) @(posedge clock);
    #1 chk_rst();
    rst = 1'b0;
    foreach (rows[i]) begin
      step(rows[i].drv);
      wait_st(rows[i].st);
      if (rows[i].en[2]) chk_f("clock enables", rows[i].en[1:0], {core_clk_en, pll_en});
      chk_f("snoop busy", {1'b0, rows[i].st == LPS_SNOOP}, {1'b0, snoop_busy});
    end
    step(9'h002);
    step(9'h000);
    step(9'h000);
    chk_f("pending awake", 2'h1, 2'(intr_pending));
    step(9'h001);
    step(9'h000);
    step(9'h000);
    chk_f("pending cleared", 2'h0, 2'(intr_pending));
    // Interrupts raised only while asleep must be dropped
    step(9'h180);
    wait_st(LPS_SLEEP);
    step(9'h182);
    step(9'h182);
    chk_f("pending in sleep", 2'h0, 2'(intr_pending));
    step(9'h1C2);
    wait_st(LPS_DEEP);
    // Stop request dropped in deep sleep must stay frozen on the link
    step(9'h0C2);
    chk_f("pending in deep", 2'h0, 2'(intr_pending));
    step(9'h182);
    wait_st(LPS_SLEEP);
    step(9'h190);
    wait_st(LPS_NORMAL);
    chk_f("requests in reset", 2'h3, {lps_if_inst.clock_stop_request_n, lps_if_inst.sleep_request_n});
    chk_f("reset active", 2'h1, 2'(reset_active));
    step(9'h000);
    repeat (20) step(9'h000);
    chk_f("platform breach", 2'h0, 2'(violation));
    chk_f("reset over", 2'h0, 2'(reset_active));
    step(9'h100);
    wait_st(LPS_STOPACK);
    // Mid-run reset with the stop request still held through release
    rst = 1'b1;
    step(9'h100);
    chk_rst();
    rst = 1'b0;
    wait_st(LPS_STOPACK);
    step(9'h000);
    wait_st(LPS_NORMAL);
    end_of_test();
  end
endmodule
